// >>> rtl/ext_bus_cycle.sv
module ext_bus_cycle
	import ext_bus_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// configuration
	input  wire logic [1:0]        mode_select,
	input  wire logic              wide_data_select,
	input  wire logic [1:0]        addr_data_mux_select,
	input  wire logic [1:0]        chip_select_function,
	input  wire logic [1:0]        setup_wait_count,
	input  wire logic [3:0]        strobe_wait_count,
	input  wire logic [1:0]        hold_wait_count,
	// requests
	input  wire logic              start_read,
	input  wire logic              start_write,
	input  wire logic [ADDR_W-1:0] address_register,
	input  wire logic [DATA_W-1:0] write_data,
	// status
	output logic                   busy,
	output logic                   cycle_done,
	output logic [DATA_W-1:0]      read_data,
	// address pins
	output logic [ADDR_W-1:0]      address_pins_out,
	output logic [ADDR_W-1:0]      address_pins_oe_b,
	// data pins
	input  wire logic [DATA_W-1:0] data_pins_in,
	output logic [DATA_W-1:0]      data_pins_out,
	output logic [DATA_W-1:0]      data_pins_oe_b,
	// control pins
	output logic                   addr_latch_low,
	output logic                   addr_latch_high,
	output logic                   read_strobe,
	output logic                   write_strobe,
	output logic                   enable_strobe,
	output logic                   chip_select_one,
	output logic                   chip_select_two
);

	typedef struct packed {
		bus_state_e        state;
		logic              second;
		logic              is_write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
		logic [DATA_W-1:0] rdata;
		logic              busy;
		logic              done;
		logic [ADDR_W-1:0] apin;
		logic [ADDR_W-1:0] apin_oe_b;
		logic [DATA_W-1:0] dpin;
		logic [DATA_W-1:0] dpin_oe_b;
		logic              all;
		logic              alh;
		logic              rd;
		logic              wr;
		logic              en;
		logic              cs1;
		logic              cs2;
	} core_s;

	core_s            cur_q;
	core_s            nxt_d;
	logic             timer_load;
	logic [CNT_W-1:0] timer_value;
	logic             phase_end;

	phase_timer u_timer (
		.clk        (clk),
		.rst_b      (rst_b),
		.load       (timer_load),
		.load_value (timer_value),
		.expired    (phase_end)
	);

	// ******************************************************
	// decoded configuration
	// ******************************************************
	logic             cs1_on;
	logic             cs2_on;
	logic [1:0]       mux;
	logic             waits_on;
	logic             master;
	logic [CNT_W-1:0] setup_len;

	always_comb
	begin
		cs2_on = (chip_select_function == CSF_BOTH) ||
			(chip_select_function == CSF_TWO);
		cs1_on = (chip_select_function == CSF_BOTH);
		// full16 falls back to full8 on narrow data
		mux = addr_data_mux_select;
		if (mux == MUX_FULL_16 && !wide_data_select)
		begin
			mux = MUX_FULL_LOW8;
		end
		// zero strobe count disables programmed waits
		waits_on = (strobe_wait_count != 4'h0);
		// only the two master modes run cycles
		master = (mode_select == MODE_SEP_STROBES) ||
			(mode_select == MODE_RW_ENABLE);
		setup_len = {3'h0, setup_wait_count} + LEN_ONE;
	end

	// ******************************************************
	// phase length, one wait state per clock
	// ******************************************************
	// lengths counted in clock cycles
	function automatic logic [CNT_W-1:0] phase_len(
		input bus_state_e st,
		input logic       wr
	);
		logic [CNT_W-1:0] len;
		len = LEN_ONE;
		case (st)
			ST_LATCH:
				len = waits_on ? setup_len : LEN_ONE;
			ST_ADDR_HOLD:
				len = LEN_ADDR_HOLD;
			ST_ADDR_REL:
				len = LEN_ADDR_REL;
			// muxed modes use it on addressing
			ST_SETUP:
				len = (waits_on && mux == MUX_DEMUX) ?
					setup_len : LEN_DEF_SETUP;
			ST_STROBE:
				len = {1'b0, strobe_wait_count} + LEN_ONE;
			// default hold one write, zero read
			ST_HOLD:
				len = waits_on ?
					({3'h0, hold_wait_count} + LEN_ONE) :
					(wr ? LEN_DEF_HOLD_W : LEN_DEF_HOLD_R);
			default:
				len = LEN_ONE;
		endcase
		return len;
	endfunction

	// ******************************************************
	// sequencer
	// ******************************************************
	always_comb
	begin
		nxt_d       = cur_q;
		nxt_d.done  = 1'b0;
		timer_load  = 1'b0;
		timer_value = LEN_ZERO;
		nxt_d.sync1 = data_pins_in;
		nxt_d.sync2 = cur_q.sync1;
		// latch, setup, strobe, hold in order
		case (cur_q.state)
			ST_IDLE:
			begin
				if (master && (start_read || start_write))
				begin
					nxt_d.is_write = start_write;
					nxt_d.addr     = address_register;
					nxt_d.wdata    = write_data;
					nxt_d.second   = 1'b0;
					nxt_d.busy     = 1'b1;
					// chip select bits read as zero
					if (mux == MUX_FULL_LOW8 || mux == MUX_FULL_16)
					begin
						if (cs2_on)
						begin
							nxt_d.addr[PIN_CS2] = 1'b0;
						end
						if (cs1_on)
						begin
							nxt_d.addr[PIN_CS1] = 1'b0;
						end
					end
					nxt_d.state = (mux == MUX_DEMUX) ?
						ST_SETUP : ST_LATCH;
				end
			end
			ST_LATCH:
			begin
				if (phase_end)
				begin
					nxt_d.state = ST_ADDR_HOLD;
				end
			end
			ST_ADDR_HOLD:
			begin
				if (phase_end)
				begin
					nxt_d.state = ST_ADDR_REL;
				end
			end
			// latch, hold, release add the latch length plus two cycles
			// second byte doubles that sum
			ST_ADDR_REL:
			begin
				if (phase_end)
				begin
					if (mux == MUX_FULL_LOW8 && !cur_q.second)
					begin
						nxt_d.second = 1'b1;
						nxt_d.state  = ST_LATCH;
					end
					else
					begin
						nxt_d.state = ST_SETUP;
					end
				end
			end
			ST_SETUP:
			begin
				if (phase_end)
				begin
					nxt_d.state = ST_STROBE;
				end
			end
			ST_STROBE:
			begin
				if (phase_end)
				begin
					if (!cur_q.is_write)
					begin
						nxt_d.rdata = wide_data_select ? cur_q.sync2 :
							{8'h00, cur_q.sync2[BYTE_W-1:0]};
					end
					if (phase_len(ST_HOLD, cur_q.is_write) == LEN_ZERO)
					begin
						nxt_d.state = ST_IDLE;
						nxt_d.busy  = 1'b0;
						nxt_d.done  = 1'b1;
					end
					else
					begin
						nxt_d.state = ST_HOLD;
					end
				end
			end
			ST_HOLD:
			begin
				if (phase_end)
				begin
					nxt_d.state = ST_IDLE;
					nxt_d.busy  = 1'b0;
					nxt_d.done  = 1'b1;
				end
			end
			default:
			begin
				nxt_d.state = ST_IDLE;
				nxt_d.busy  = 1'b0;
			end
		endcase
		if (nxt_d.state != cur_q.state ||
			nxt_d.second != cur_q.second)
		begin
			timer_load  = 1'b1;
			timer_value = phase_len(nxt_d.state, nxt_d.is_write)
				- LEN_ONE;
		end

		// ******************************************************
		// pin drive for the coming cycle
		// ******************************************************
		nxt_d.apin      = nxt_d.addr;
		nxt_d.apin_oe_b = '1;
		nxt_d.dpin      = '0;
		nxt_d.dpin_oe_b = '1;
		nxt_d.all       = 1'b0;
		nxt_d.alh       = 1'b0;
		nxt_d.rd        = 1'b0;
		nxt_d.wr        = 1'b0;
		nxt_d.en        = 1'b0;
		nxt_d.cs1       = 1'b0;
		nxt_d.cs2       = 1'b0;
		if (nxt_d.busy)
		begin
			case (mux)
				// all address bits on address pins
				MUX_DEMUX:
					nxt_d.apin_oe_b = '0;
				// high byte stays on pins 15..8
				// pins 7..0 released, pin 0 included
				MUX_PARTIAL:
					nxt_d.apin_oe_b = 16'h00FF;
				default:
					nxt_d.apin_oe_b = 16'h3FFF;
			endcase
			// chip selects take pins 15 and 14
			if (cs2_on)
			begin
				nxt_d.apin_oe_b[PIN_CS2] = 1'b1;
			end
			if (cs1_on)
			begin
				nxt_d.apin_oe_b[PIN_CS1] = 1'b1;
			end
			// selects held for the whole cycle
			nxt_d.cs2 = cs2_on;
			nxt_d.cs1 = cs1_on;
			// rw line high for read in mode 11
			if (mode_select == MODE_RW_ENABLE)
			begin
				nxt_d.rd = !nxt_d.is_write;
			end
		end
		case (nxt_d.state)
			ST_LATCH, ST_ADDR_HOLD:
			begin
				nxt_d.dpin_oe_b = (mux == MUX_FULL_16) ?
					16'h0000 : 16'hFF00;
				// low byte first, then high byte
				// whole address on 16 data pins
				if (mux == MUX_FULL_16)
				begin
					nxt_d.dpin = nxt_d.addr;
				end
				else if (nxt_d.second)
				begin
					nxt_d.dpin = {8'h00, nxt_d.addr[15:8]};
				end
				else
				begin
					nxt_d.dpin = {8'h00, nxt_d.addr[7:0]};
				end
				if (nxt_d.state == ST_LATCH)
				begin
					nxt_d.all = (mux != MUX_FULL_LOW8) ||
						!nxt_d.second;
					nxt_d.alh = (mux == MUX_FULL_16) ||
						(mux == MUX_FULL_LOW8 && nxt_d.second);
				end
			end
			ST_SETUP, ST_STROBE, ST_HOLD:
			begin
				// data width picks the data pins
				if (nxt_d.is_write)
				begin
					nxt_d.dpin      = nxt_d.wdata;
					nxt_d.dpin_oe_b = wide_data_select ?
						16'h0000 : 16'hFF00;
				end
				if (nxt_d.state == ST_STROBE)
				begin
					if (mode_select == MODE_RW_ENABLE)
					begin
						nxt_d.en = 1'b1;
					end
					else
					begin
						nxt_d.rd = !nxt_d.is_write;
						nxt_d.wr = nxt_d.is_write;
					end
				end
			end
			default:
			begin
				nxt_d.dpin_oe_b = '1;
			end
		endcase
	end

	// ******************************************************
	// state register
	// ******************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cur_q           <= '0;
			cur_q.state     <= ST_IDLE;
			cur_q.apin_oe_b <= '1;
			cur_q.dpin_oe_b <= '1;
		end
		else
		begin
			cur_q <= nxt_d;
		end
	end

	// ******************************************************
	// outputs
	// ******************************************************
	assign busy              = cur_q.busy;
	assign cycle_done        = cur_q.done;
	assign read_data         = cur_q.rdata;
	assign address_pins_out  = cur_q.apin;
	assign address_pins_oe_b = cur_q.apin_oe_b;
	assign data_pins_out     = cur_q.dpin;
	assign data_pins_oe_b    = cur_q.dpin_oe_b;
	assign addr_latch_low    = cur_q.all;
	assign addr_latch_high   = cur_q.alh;
	assign read_strobe       = cur_q.rd;
	assign write_strobe      = cur_q.wr;
	assign enable_strobe     = cur_q.en;
	assign chip_select_one   = cur_q.cs1;
	assign chip_select_two   = cur_q.cs2;

endmodule

// >>> rtl/ext_bus_pkg.sv
// shared constants and types for the external bus cycle sequencer
package ext_bus_pkg;

	// ******************************************************
	// configuration encodings
	// ******************************************************
	localparam logic [1:0] MUX_DEMUX     = 2'h0;
	localparam logic [1:0] MUX_PARTIAL   = 2'h1;
	localparam logic [1:0] MUX_FULL_LOW8 = 2'h2;
	localparam logic [1:0] MUX_FULL_16   = 2'h3;

	localparam logic [1:0] MODE_SEP_STROBES = 2'h2;
	localparam logic [1:0] MODE_RW_ENABLE   = 2'h3;

	localparam logic [1:0] CSF_BOTH    = 2'h2;
	localparam logic [1:0] CSF_TWO     = 2'h1;
	localparam logic [1:0] CSF_NONE    = 2'h0;

	// ******************************************************
	// widths and pin positions
	// ******************************************************
	localparam int ADDR_W   = 16;
	localparam int DATA_W   = 16;
	localparam int BYTE_W   = 8;
	localparam int CNT_W    = 5;
	localparam int PIN_CS2  = 15;
	localparam int PIN_CS1  = 14;
	localparam int PIN_ALH  = 1;
	localparam int PIN_ALL  = 0;

	// ******************************************************
	// phase lengths in clock cycles
	// ******************************************************
	localparam logic [CNT_W-1:0] LEN_ONE        = 5'h01;
	localparam logic [CNT_W-1:0] LEN_ZERO       = 5'h00;
	localparam logic [CNT_W-1:0] LEN_ADDR_HOLD  = 5'h01;
	localparam logic [CNT_W-1:0] LEN_ADDR_REL   = 5'h01;
	localparam logic [CNT_W-1:0] LEN_DEF_SETUP  = 5'h01;
	localparam logic [CNT_W-1:0] LEN_DEF_HOLD_W = 5'h01;
	localparam logic [CNT_W-1:0] LEN_DEF_HOLD_R = 5'h00;

	// ******************************************************
	// sequencer states
	// ******************************************************
	typedef enum logic [6:0] {
		ST_IDLE      = 7'h01,
		ST_LATCH     = 7'h02,
		ST_ADDR_HOLD = 7'h04,
		ST_ADDR_REL  = 7'h08,
		ST_SETUP     = 7'h10,
		ST_STROBE    = 7'h20,
		ST_HOLD      = 7'h40
	} bus_state_e;

endpackage

// >>> rtl/phase_timer.sv
// down counter that times one bus phase
module phase_timer
	import ext_bus_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// control
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_value,
	// status
	output logic                  expired
);

	typedef struct packed {
		logic [CNT_W-1:0] count;
	} timer_s;

	timer_s cur_q;
	timer_s nxt_d;

	// ******************************************************
	// one count per clock cycle
	// ******************************************************
	always_comb
	begin
		nxt_d = cur_q;
		if (load)
		begin
			nxt_d.count = load_value;
		end
		else if (cur_q.count != '0)
		begin
			nxt_d.count = cur_q.count - 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cur_q <= '0;
		end
		else
		begin
			cur_q <= nxt_d;
		end
	end

	assign expired = (cur_q.count == '0);

endmodule

// >>> tb/ext_bus_cycle_properties.sv
// assertion checker for the external bus cycle sequencer
module ext_bus_cycle_properties
	import ext_bus_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_b,
	// configuration
	input wire logic [1:0]        mode_select,
	input wire logic              wide_data_select,
	input wire logic [1:0]        addr_data_mux_select,
	input wire logic [1:0]        chip_select_function,
	input wire logic [1:0]        setup_wait_count,
	input wire logic [3:0]        strobe_wait_count,
	// request and status
	input wire logic [ADDR_W-1:0] address_register,
	input wire logic              busy,
	input wire logic              cycle_done,
	// pins
	input wire logic [ADDR_W-1:0] address_pins_out,
	input wire logic [ADDR_W-1:0] address_pins_oe_b,
	input wire logic              addr_latch_low,
	input wire logic              addr_latch_high,
	input wire logic              read_strobe,
	input wire logic              write_strobe,
	input wire logic              enable_strobe,
	input wire logic              chip_select_one,
	input wire logic              chip_select_two
);
	timeunit 1ns;
	timeprecision 1ns;

	// *****
	// helper counters
	// *****
	logic       stb;
	logic       full8;
	logic [2:0] lat_n_q;
	logic [4:0] stb_n_q;

	assign stb = (mode_select == MODE_RW_ENABLE) ? enable_strobe
		: read_strobe | write_strobe;
	assign full8 = addr_data_mux_select == MUX_FULL_LOW8
		|| (addr_data_mux_select == MUX_FULL_16 && !wide_data_select);

	always_ff @(posedge clk)
	begin
		lat_n_q <= addr_latch_low ? lat_n_q + 3'h1 : 3'h0;
		stb_n_q <= stb ? stb_n_q + 5'h01 : 5'h00;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence high_follows;
		##[1:3] $rose(addr_latch_high);
	endsequence

	// *****
	// properties
	// *****
	a_strobe_excl: assert property (
		mode_select == MODE_SEP_STROBES |-> !(read_strobe && write_strobe))
		else $error("read and write strobes together");
	a_done_after: assert property ($fell(busy) |-> cycle_done)
		else $error("busy fell without done pulse");
	a_select_decode: assert property (busy |->
		chip_select_one == (chip_select_function == CSF_BOTH)
		&& chip_select_two == (chip_select_function == CSF_BOTH
		|| chip_select_function == CSF_TWO))
		else $error("chip select levels wrong while busy");
	a_latch_pair: assert property (
		addr_data_mux_select == MUX_FULL_16 && wide_data_select
		|-> addr_latch_low == addr_latch_high)
		else $error("latches apart in full 16 pin mode");
	a_latch_order: assert property (
		full8 && $fell(addr_latch_low) |-> high_follows)
		else $error("high latch did not follow low latch");
	a_latch_len: assert property ($fell(addr_latch_low) |->
		lat_n_q == ((strobe_wait_count != 4'h0)
		? setup_wait_count + 3'h1 : 3'h1))
		else $error("low latch length wrong");
	a_strobe_len: assert property ($fell(stb) |->
		stb_n_q == strobe_wait_count + 5'h01)
		else $error("strobe length wrong");
	a_demux_addr: assert property (stb
		&& addr_data_mux_select == MUX_DEMUX
		&& chip_select_function == CSF_NONE
		|-> address_pins_out == address_register
		&& address_pins_oe_b == 16'h0000)
		else $error("demultiplexed address not on pins");
	a_partial_rel: assert property (
		busy && addr_data_mux_select == MUX_PARTIAL
		|-> address_pins_oe_b[7:0] == 8'hFF)
		else $error("low address pins driven in partial mode");
endmodule

bind ext_bus_cycle ext_bus_cycle_properties i_ext_bus_cycle_properties (.*);

// >>> tb/ext_peripheral_model.sv
// model of the peripheral on the far side of the bus pins
module ext_peripheral_model
	import ext_bus_pkg::*;
(
	// clock
	input wire logic              clk,
	// pins from the sequencer
	input wire logic [1:0]        mode_select,
	input wire logic [DATA_W-1:0] data_pins_out,
	input wire logic [DATA_W-1:0] data_pins_oe_b,
	input wire logic [ADDR_W-1:0] address_pins_out,
	input wire logic              addr_latch_low,
	input wire logic              addr_latch_high,
	input wire logic              read_strobe,
	input wire logic              write_strobe,
	input wire logic              enable_strobe,
	// bench side
	input wire logic [DATA_W-1:0] rd_value,
	output logic [DATA_W-1:0]     data_pins_in,
	output logic [ADDR_W-1:0]     lat_addr,
	output logic [DATA_W-1:0]     wr_seen
);
	timeunit 1ns;
	timeprecision 1ns;

	logic              rw;
	logic              rd_act;
	logic              wr_act;
	logic [DATA_W-1:0] last_q = 16'h0000;

	assign rw = mode_select == MODE_RW_ENABLE;
	assign rd_act = rw ? enable_strobe & read_strobe : read_strobe;
	assign wr_act = rw ? enable_strobe & !read_strobe : write_strobe;
	assign data_pins_in = (~data_pins_oe_b & data_pins_out)
		| (data_pins_oe_b & (rd_act ? rd_value : ~last_q));

	always_ff @(posedge clk)
	begin
		last_q <= data_pins_in;
		if (addr_latch_low && addr_latch_high)
			lat_addr <= data_pins_out;
		else if (addr_latch_low)
			lat_addr <= {address_pins_out[15:8], data_pins_out[7:0]};
		else if (addr_latch_high)
			lat_addr[15:8] <= data_pins_out[7:0];
		if (wr_act)
			wr_seen <= data_pins_out;
	end
endmodule

// >>> tb/tb.sv
// self-checking bench for the external bus cycle sequencer
`define CHK(name, exp, got) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("CHECK FAILED %s exp %h seen %h", name, exp, got); \
		end \
	end

module tb
	import ext_bus_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0;
	logic        rst_b, wide_data_select, start_read, start_write;
	logic        busy, cycle_done, addr_latch_low, addr_latch_high;
	logic        read_strobe, write_strobe, enable_strobe;
	logic        chip_select_one, chip_select_two;
	logic [1:0]  mode_select, addr_data_mux_select, chip_select_function;
	logic [1:0]  setup_wait_count, hold_wait_count;
	logic [3:0]  strobe_wait_count;
	logic [15:0] address_register, write_data, read_data, data_pins_in;
	logic [15:0] address_pins_out, address_pins_oe_b, data_pins_out;
	logic [15:0] data_pins_oe_b, rd_value, lat_addr, wr_seen;
	int          n_mismatch = 0, total_checks = 0, cyc = 0, tn = 0;

	ext_bus_cycle i_ext_bus_cycle (.*);
	ext_peripheral_model i_ext_peripheral_model (.*);

	always #20 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// expected cycle length in clocks, request edge to done
	function automatic int exp_len(logic [1:0] mx, logic wd, logic wr,
		logic [1:0] sw, logic [3:0] mw, logic [1:0] hw);
		int l, a, s, h;
		l = (mw != 4'h0) ? sw + 1 : 1;
		a = (mx == MUX_DEMUX) ? 0 : 2 + l;
		if (mx == MUX_FULL_LOW8 || (mx == MUX_FULL_16 && !wd))
			a = 2 * a;
		s = (mx == MUX_DEMUX && mw != 4'h0) ? sw + 1 : 1;
		h = (mw != 4'h0) ? hw + 1 : int'(wr);
		return a + s + mw + 1 + h + 1;
	endfunction

	task automatic run(input logic [1:0] md, mx, cs, sw,
		input logic [3:0] mw, input logic [1:0] hw,
		input logic wd, wr, input logic [15:0] a, d);
		int          n;
		logic [15:0] m;
		@(posedge clk);
		{mode_select, addr_data_mux_select, chip_select_function} <= {md, mx, cs};
		{setup_wait_count, strobe_wait_count, hold_wait_count} <= {sw, mw, hw};
		{wide_data_select, address_register, write_data} <= {wd, a, d};
		rd_value <= d;
		@(posedge clk);
		{start_write, start_read} <= {wr, !wr};
		@(posedge clk);
		{start_write, start_read} <= 2'h0;
		n = 1;
		do
		begin
			@(posedge clk);
			n++;
			#1;
		end while (cycle_done !== 1'b1 && n < 64);
		`CHK("cycle length", exp_len(mx, wd, wr, sw, mw, hw), n)
		`CHK("pins released", 32'hFFFFFFFF,
			{address_pins_oe_b, data_pins_oe_b})
		m = (cs == CSF_BOTH) ? 16'h3FFF : (cs == CSF_TWO) ? 16'h7FFF : 16'hFFFF;
		if (mx == MUX_PARTIAL)
			`CHK("latched address", a & m, lat_addr & m)
		else if (mx != MUX_DEMUX)
			`CHK("latched address", a & m, lat_addr)
		if (!wr && mw >= 4'h3)
			`CHK("read data", wd ? d : {8'h00, d[7:0]}, read_data)
		if (wr)
			`CHK("write data", wd ? d : {8'h00, d[7:0]},
				wd ? wr_seen : {8'h00, wr_seen[7:0]})
		tn++;
		$display("test %0d done", tn);
	endtask

	initial
	begin
		{rst_b, start_read, start_write, wide_data_select} = 4'h0;
		{mode_select, addr_data_mux_select, chip_select_function} = 6'h00;
		{setup_wait_count, strobe_wait_count, hold_wait_count} = 8'h00;
		{address_register, write_data, rd_value} = 48'h0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		run(2'h2, 2'h0, 2'h2, 2'h0, 4'h0, 2'h0, 1, 1, 16'hA5C3, 16'h1E2D);
		run(2'h2, 2'h0, 2'h2, 2'h3, 4'h0, 2'h3, 1, 0, 16'h0F0F, 16'h4321);
		run(2'h3, 2'h0, 2'h1, 2'h2, 4'h3, 2'h1, 0, 0, 16'hC001, 16'h00B7);
		run(2'h2, 2'h0, 2'h0, 2'h3, 4'hF, 2'h3, 1, 1, 16'hFEDC, 16'h9876);
		run(2'h2, 2'h1, 2'h2, 2'h0, 4'h0, 2'h0, 1, 0, 16'h5A3C, 16'h0000);
		run(2'h2, 2'h1, 2'h0, 2'h1, 4'h2, 2'h0, 0, 1, 16'hE7B4, 16'h0069);
		run(2'h3, 2'h1, 2'h1, 2'h3, 4'h3, 2'h0, 1, 0, 16'h8421, 16'hBEEF);
		run(2'h2, 2'h2, 2'h2, 2'h0, 4'h0, 2'h0, 0, 1, 16'hFFFF, 16'h00A1);
		run(2'h3, 2'h2, 2'h1, 2'h2, 4'h4, 2'h2, 1, 0, 16'hC3A5, 16'h7E81);
		run(2'h2, 2'h3, 2'h2, 2'h1, 4'h1, 2'h1, 1, 1, 16'hD00D, 16'h3C5A);
		run(2'h2, 2'h3, 2'h0, 2'h0, 4'h3, 2'h0, 1, 0, 16'h6B2F, 16'hA55A);
		run(2'h2, 2'h3, 2'h1, 2'h0, 4'h0, 2'h0, 0, 1, 16'hF123, 16'h0042);
		run(2'h3, 2'h0, 2'h2, 2'h1, 4'h2, 2'h2, 1, 1, 16'h1234, 16'h5E71);
		// reset in the middle of a cycle
		@(posedge clk);
		start_write <= 1'b1;
		@(posedge clk);
		start_write <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		`CHK("busy after reset", 1'b0, busy)
		`CHK("pins after reset", 32'hFFFFFFFF,
			{address_pins_oe_b, data_pins_oe_b})
		$display("reset test done");
		@(posedge clk);
		mode_select <= 2'h0;
		start_read <= 1'b1;
		@(posedge clk);
		start_read <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		`CHK("busy in idle mode", 1'b0, busy)
		$display("idle mode test done");
		wrap_up();
	end
endmodule
